// file: rtl/ictr_pkg.sv
package ictr_pkg;

  // ==========================================================================
  // Modes, widths and counter constants.
  // ==========================================================================
  localparam int CNT_W = 16;

  typedef enum logic [2:0] {
    MODE_ONE_SHOT  = 3'h1,
    MODE_RATE      = 3'h2,
    MODE_SQUARE    = 3'h3,
    MODE_SW_STROBE = 3'h4,
    MODE_HW_STROBE = 3'h5
  } mode_t;

  localparam logic [CNT_W-1:0] CNT_ZERO    = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE     = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_TWO     = 16'h0002;
  localparam logic [CNT_W-1:0] BCD_TOP     = 16'h9999;
  localparam logic [CNT_W-1:0] BIN_TOP     = 16'hffff;
  localparam logic [2:0]       RESET_MODE  = 3'h2;
  localparam int               CHANNELS    = 3;

endpackage : ictr_pkg

// file: rtl/ictr_if.sv
`timescale 1ns/1ns
interface ictr_if;
  import ictr_pkg::*;
  logic             raw_clk;
  logic             raw_gate;
  logic             clk_rise;
  logic             clk_fall;
  logic             gate_lvl;
  logic             gate_rise;
  modport sync_side (input raw_clk, raw_gate, output clk_rise, clk_fall, gate_lvl, gate_rise);
  modport core_side (input clk_rise, clk_fall, gate_lvl, gate_rise);
endinterface : ictr_if

// file: rtl/ictr_sync.sv
`timescale 1ns/1ns
module ictr_sync
  import ictr_pkg::*;
(
  // Clock and reset.
  input  wire logic clk_in,
  input  wire logic srst_in,
  // Pins toward the channel.
  ictr_if.sync_side pins
);

  typedef struct packed {
    logic [1:0] clk_s;
    logic [1:0] gate_s;
    logic       clk_d;
    logic       gate_d;
  } sync_st_t;

  sync_st_t st_ff;
  sync_st_t nxt_st;

  // ==========================================================================
  // Two-stage synchronisers and edge detection.
  // ==========================================================================
  always_comb begin
    nxt_st        = st_ff;
    nxt_st.clk_s  = {st_ff.clk_s[0], pins.raw_clk};
    nxt_st.gate_s = {st_ff.gate_s[0], pins.raw_gate};
    nxt_st.clk_d  = st_ff.clk_s[1];
    nxt_st.gate_d = st_ff.gate_s[1];
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pins.clk_rise  = st_ff.clk_s[1] & ~st_ff.clk_d;
  assign pins.clk_fall  = ~st_ff.clk_s[1] & st_ff.clk_d;
  assign pins.gate_lvl  = st_ff.gate_s[1];
  assign pins.gate_rise = st_ff.gate_s[1] & ~st_ff.gate_d;

endmodule : ictr_sync

// file: rtl/interval_counter.sv
`timescale 1ns/1ns
module interval_counter
  import ictr_pkg::*;
(
  // Clock and reset.
  input  wire logic             clk_in,
  input  wire logic             srst_in,
  // Host programming strobes.
  input  wire logic             ctrl_wr_in,
  input  wire logic [2:0]       ctrl_mode_in,
  input  wire logic             ctrl_bcd_in,
  input  wire logic             ctrl_two_byte_in,
  input  wire logic             cnt_wr_in,
  input  wire logic [7:0]       cnt_byte_in,
  // Link pins.
  input  wire logic             cnt_clk_in,
  input  wire logic             count_enable_in,
  // Status and output.
  output logic                  waveform_out,
  output logic [CNT_W-1:0]      count_out,
  output logic                  null_count_out
);

  ictr_if pins ();

  assign pins.raw_clk  = cnt_clk_in;
  assign pins.raw_gate = count_enable_in;

  ictr_sync u_sync (
    .clk_in  (clk_in),
    .srst_in (srst_in),
    .pins    (pins.sync_side)
  );

  typedef struct packed {
    logic [2:0]       mode;
    logic             bcd;
    logic             two_byte;
    logic             lsb_next;
    logic [CNT_W-1:0] hold;
    logic             pending;
    logic             armed;
    logic             trig;
    logic             gate_smp;
    logic             load_req;
    logic [CNT_W-1:0] ce;
    logic             out;
    logic             running;
    logic             odd_fall;
  } ch_st_t;

  ch_st_t st_ff;
  ch_st_t nxt_st;

  // ==========================================================================
  // Helper functions for decrement and square wave loads.
  // ==========================================================================
  function automatic logic [CNT_W-1:0] dec_by(input logic [CNT_W-1:0] v,
                                              input logic bcd,
                                              input logic [CNT_W-1:0] step);
    logic [CNT_W-1:0] r;
    logic [3:0]       d;
    logic             br;
    r  = v;
    br = 1'b0;
    if (!bcd) begin
      r = v - step;
    end else begin
      for (int i = 0; i < 4; i++) begin
        d  = v[i*4 +: 4];
        if (i == 0) begin
          if (d < step[3:0] + {3'h0, br}) begin
            d  = d + 4'ha - step[3:0];
            br = 1'b1;
          end else begin
            d  = d - step[3:0];
            br = 1'b0;
          end
        end else begin
          if (br) begin
            if (d == 4'h0) begin
              d  = 4'h9;
            end else begin
              d  = d - 4'h1;
              br = 1'b0;
            end
          end
        end
        r[i*4 +: 4] = d;
      end
    end
    return r;
  endfunction : dec_by

  function automatic logic [CNT_W-1:0] even_part(input logic [CNT_W-1:0] v);
    return {v[CNT_W-1:1], 1'b0};
  endfunction : even_part

  // ==========================================================================
  // Channel state machine.
  // ==========================================================================
  logic             at_one;
  logic             at_zero;
  logic             expire;
  logic [CNT_W-1:0] dec1;
  logic [CNT_W-1:0] dec2;

  assign at_one  = (st_ff.ce == CNT_ONE);
  assign at_zero = (st_ff.ce == CNT_ZERO);
  assign dec1    = dec_by(st_ff.ce, st_ff.bcd, CNT_ONE);
  assign dec2    = dec_by(st_ff.ce, st_ff.bcd, CNT_TWO);
  assign expire  = (st_ff.ce == CNT_TWO) | at_zero;

  always_comb begin
    nxt_st = st_ff;
    if (pins.clk_rise) begin
      nxt_st.gate_smp = pins.gate_lvl;
      nxt_st.trig     = 1'b0;
      if (st_ff.trig) begin
        nxt_st.load_req = 1'b1;
      end
    end
    if (pins.gate_rise) begin
      nxt_st.trig = 1'b1;
    end
    if (pins.clk_fall) begin
      nxt_st.load_req = 1'b0;
      case (mode_t'(st_ff.mode))
        MODE_ONE_SHOT: begin
          if (st_ff.load_req && st_ff.armed) begin
            nxt_st.ce      = st_ff.hold;
            nxt_st.out     = 1'b0;
            nxt_st.pending = 1'b0;
            nxt_st.running = 1'b1;
          end else if (st_ff.running) begin
            nxt_st.ce = dec1;
            if (at_one) begin
              nxt_st.out     = 1'b1;
              nxt_st.running = 1'b0;
            end
          end else begin
            nxt_st.ce = dec1;
          end
        end
        MODE_RATE: begin
          if (st_ff.armed && (st_ff.pending || st_ff.load_req || !st_ff.running)
              && (st_ff.load_req || !st_ff.running)) begin
            nxt_st.ce      = st_ff.hold;
            nxt_st.pending = 1'b0;
            nxt_st.running = 1'b1;
            nxt_st.out     = 1'b1;
          end else if (st_ff.running && st_ff.gate_smp) begin
            if (at_one) begin
              nxt_st.out     = 1'b1;
              nxt_st.ce      = st_ff.hold;
              nxt_st.pending = 1'b0;
            end else begin
              nxt_st.ce  = dec1;
              nxt_st.out = ~(dec1 == CNT_ONE);
            end
          end
        end
        MODE_SQUARE: begin
          if (st_ff.armed && (st_ff.load_req || !st_ff.running)) begin
            nxt_st.ce       = even_part(st_ff.hold);
            nxt_st.pending  = 1'b0;
            nxt_st.running  = 1'b1;
            nxt_st.out      = 1'b1;
            nxt_st.odd_fall = 1'b0;
          end else if (st_ff.running && st_ff.gate_smp) begin
            if (st_ff.odd_fall) begin
              nxt_st.out      = 1'b0;
              nxt_st.odd_fall = 1'b0;
              nxt_st.ce       = even_part(st_ff.hold);
              nxt_st.pending  = 1'b0;
            end else if (expire) begin
              nxt_st.pending = 1'b0;
              if (st_ff.out && st_ff.hold[0]) begin
                nxt_st.odd_fall = 1'b1;
                nxt_st.ce       = dec2;
              end else begin
                nxt_st.out = ~st_ff.out;
                nxt_st.ce  = even_part(st_ff.hold);
              end
            end else begin
              nxt_st.ce = dec2;
            end
          end
        end
        MODE_SW_STROBE: begin
          if (st_ff.pending) begin
            nxt_st.ce      = st_ff.hold;
            nxt_st.pending = 1'b0;
            nxt_st.running = 1'b1;
            nxt_st.out     = 1'b1;
          end else if (st_ff.gate_smp) begin
            nxt_st.ce = dec1;
            if (st_ff.running && at_one) begin
              nxt_st.out = 1'b0;
            end else begin
              nxt_st.out = 1'b1;
            end
            if (st_ff.running && at_one) begin
              nxt_st.running = 1'b0;
            end
          end else begin
            nxt_st.out = 1'b1;
          end
        end
        default: begin
          if (st_ff.load_req && st_ff.armed) begin
            nxt_st.ce      = st_ff.hold;
            nxt_st.pending = 1'b0;
            nxt_st.running = 1'b1;
            nxt_st.out     = 1'b1;
          end else begin
            nxt_st.ce = dec1;
            if (st_ff.running && at_one) begin
              nxt_st.out     = 1'b0;
              nxt_st.running = 1'b0;
            end else begin
              nxt_st.out = 1'b1;
            end
          end
        end
      endcase
    end
    // In modes 2 and 3, level low on the enable forces the output high without a clock.
    if ((st_ff.mode == MODE_RATE || st_ff.mode == MODE_SQUARE) && !pins.gate_lvl) begin
      nxt_st.out = 1'b1;
    end
    if (cnt_wr_in) begin
      if (st_ff.two_byte && st_ff.lsb_next) begin
        nxt_st.hold[7:0] = cnt_byte_in;
        nxt_st.lsb_next  = 1'b0;
      end else begin
        if (st_ff.two_byte) begin
          nxt_st.hold[15:8] = cnt_byte_in;
        end else begin
          nxt_st.hold = {8'h00, cnt_byte_in};
        end
        nxt_st.lsb_next = 1'b1;
        nxt_st.pending  = 1'b1;
        nxt_st.armed    = 1'b1;
      end
    end
    if (ctrl_wr_in) begin
      nxt_st          = '0;
      nxt_st.mode     = ctrl_mode_in;
      nxt_st.bcd      = ctrl_bcd_in;
      nxt_st.two_byte = ctrl_two_byte_in;
      nxt_st.lsb_next = 1'b1;
      nxt_st.out      = 1'b1;
      nxt_st.gate_smp = pins.gate_lvl;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      st_ff          <= '0;
      st_ff.mode     <= RESET_MODE;
      st_ff.lsb_next <= 1'b1;
      st_ff.out      <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Output goes high at once on a control write; enable fall acts only through the synchroniser.
  assign waveform_out   = ctrl_wr_in ? 1'b1 : st_ff.out;
  assign count_out      = st_ff.ce;
  assign null_count_out = st_ff.pending;

endmodule : interval_counter

// file: sim/ictr_checker.sv
`timescale 1ns/1ns
module ictr_checker
  import ictr_pkg::*;
(
  // Clock and reset.
  input wire logic             clk_in,
  input wire logic             srst_in,
  // Host strobes and pins.
  input wire logic             ctrl_wr_in,
  input wire logic [2:0]       ctrl_mode_in,
  input wire logic             ctrl_two_byte_in,
  input wire logic             cnt_wr_in,
  input wire logic             cnt_clk_in,
  input wire logic             count_enable_in,
  // Outputs.
  input wire logic             waveform_out,
  input wire logic [CNT_W-1:0] count_out,
  input wire logic             null_count_out
);
  // ======
  // Helper state.
  logic [2:0] mode_ff;
  logic       two_ff;
  logic       half_ff;
  logic       clk_d_ff;
  logic [3:0] since_ff;
  logic [3:0] low_ff;
  always_ff @(posedge clk_in) begin
    clk_d_ff <= cnt_clk_in;
    since_ff <= (clk_d_ff && !cnt_clk_in) ? 4'h0 : since_ff + 4'(since_ff != 4'hf);
    low_ff   <= count_enable_in ? 4'h0 : low_ff + 4'(low_ff != 4'hf);
    if (srst_in) begin
      mode_ff <= RESET_MODE;
      two_ff  <= 1'b0;
      half_ff <= 1'b0;
    end else if (ctrl_wr_in) begin
      mode_ff <= ctrl_mode_in;
      two_ff  <= ctrl_two_byte_in;
      half_ff <= 1'b0;
    end else if (cnt_wr_in && two_ff) begin
      half_ff <= !half_ff;
    end
  end
  // ======
  // Assertions.
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  sequence s_clocked;
    since_ff inside {[4'h1:4'h5]};
  endsequence
  sequence s_low_period;
    !waveform_out [*7] ##1 waveform_out;
  endsequence
  property p_reset_state;
    $fell(srst_in) |-> waveform_out && count_out == CNT_ZERO;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("bad state after reset");
  property p_ctrl_high;
    ctrl_wr_in |-> waveform_out;
  endproperty
  a_ctrl_high: assert property (p_ctrl_high) else $error("output low at control write");
  property p_null_set;
    cnt_wr_in && !ctrl_wr_in && (!two_ff || half_ff) |=> null_count_out;
  endproperty
  a_null_set: assert property (p_null_set) else $error("null count not set");
  property p_count_cause;
    !$stable(count_out) && !$past(ctrl_wr_in) |-> s_clocked;
  endproperty
  a_count_cause: assert property (p_count_cause) else $error("count moved off clock fall");
  property p_fall_cause;
    $fell(waveform_out) |-> s_clocked;
  endproperty
  a_fall_cause: assert property (p_fall_cause) else $error("output fell off clock fall");
  property p_strobe_one;
    $fell(waveform_out) && mode_ff inside {3'h4, 3'h5} |=> s_low_period;
  endproperty
  a_strobe_one: assert property (p_strobe_one) else $error("strobe not one pulse");
  property p_gate_high;
    mode_ff inside {3'h2, 3'h3} && $fell(count_enable_in) |-> ##[1:5] waveform_out;
  endproperty
  a_gate_high: assert property (p_gate_high) else $error("gate low did not set output");
  property p_gate_hold;
    mode_ff == 3'h4 && low_ff > 4'h7 && !null_count_out && !$past(null_count_out)
      |-> $stable(count_out);
  endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("counted with gate low");
endmodule : ictr_checker

bind interval_counter ictr_checker ictr_checker_inst (
  .clk_in(clk_in), .srst_in(srst_in), .ctrl_wr_in(ctrl_wr_in), .ctrl_mode_in(ctrl_mode_in),
  .ctrl_two_byte_in(ctrl_two_byte_in), .cnt_wr_in(cnt_wr_in), .cnt_clk_in(cnt_clk_in),
  .count_enable_in(count_enable_in), .waveform_out(waveform_out), .count_out(count_out),
  .null_count_out(null_count_out));

// file: sim/ictr_host.sv
`timescale 1ns/1ns
module ictr_host
  import ictr_pkg::*;
(
  // Clock.
  input  wire logic clk_in,
  // Programming strobes.
  output logic       ctrl_wr_out,
  output logic [2:0] ctrl_mode_out,
  output logic       ctrl_bcd_out,
  output logic       ctrl_two_byte_out,
  output logic       cnt_wr_out,
  output logic [7:0] cnt_byte_out
);
  // ======
  // Bus cycles, entered just after a rising edge.
  initial begin
    ctrl_wr_out = 1'b0;
    ctrl_mode_out = RESET_MODE;
    ctrl_bcd_out = 1'b0;
    ctrl_two_byte_out = 1'b0;
    cnt_wr_out = 1'b0;
    cnt_byte_out = 8'h00;
  end
  task automatic put_ctrl(input logic [2:0] mode, input logic two);
    ctrl_mode_out = mode;
    ctrl_two_byte_out = two;
    ctrl_wr_out = 1'b1;
    @(posedge clk_in);
    #2;
    ctrl_wr_out = 1'b0;
  endtask : put_ctrl
  task automatic put_count(input logic [15:0] cnt, input logic two);
    if (ctrl_mode_out == 3'h2 && cnt == CNT_ONE) cnt = CNT_TWO;
    cnt_byte_out = cnt[7:0];
    cnt_wr_out = 1'b1;
    @(posedge clk_in);
    #2;
    if (two) begin
      cnt_byte_out = cnt[15:8];
      @(posedge clk_in);
      #2;
    end
    cnt_wr_out = 1'b0;
    cnt_byte_out = ~cnt_byte_out;
  endtask : put_count
endmodule : ictr_host

// file: sim/interval_counter_bench.sv
`timescale 1ns/1ns
module interval_counter_bench;
  import ictr_pkg::*;
  logic             clk_in;
  logic             srst_in;
  logic             cnt_clk_in;
  logic             count_enable_in;
  logic             mute;
  logic             ctrl_wr;
  logic [2:0]       ctrl_mode;
  logic             ctrl_bcd;
  logic             two_byte;
  logic             cnt_wr;
  logic [7:0]       cnt_byte;
  logic             waveform_out;
  logic             null_count_out;
  logic [CNT_W-1:0] count_out;
  logic [15:0]      notes[$];
  int               pulses = 0;
  int               ref_p = 0;
  int               failures = 0;
  int               samples_checked = 0;
  int               cycles = 0;
  int               n;
  ictr_host ictr_host_inst (.clk_in(clk_in), .ctrl_wr_out(ctrl_wr), .ctrl_mode_out(ctrl_mode),
    .ctrl_bcd_out(ctrl_bcd), .ctrl_two_byte_out(two_byte), .cnt_wr_out(cnt_wr),
    .cnt_byte_out(cnt_byte));
  interval_counter interval_counter_inst (.clk_in(clk_in), .srst_in(srst_in),
    .ctrl_wr_in(ctrl_wr), .ctrl_mode_in(ctrl_mode), .ctrl_bcd_in(ctrl_bcd),
    .ctrl_two_byte_in(two_byte), .cnt_wr_in(cnt_wr), .cnt_byte_in(cnt_byte),
    .cnt_clk_in(cnt_clk_in), .count_enable_in(count_enable_in), .waveform_out(waveform_out),
    .count_out(count_out), .null_count_out(null_count_out));
  // ======
  // Clocks, pulse count and timeout.
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  initial begin
    cnt_clk_in = 1'b1;
    #13;
    forever #200 cnt_clk_in = ~cnt_clk_in;
  end
  always @(negedge cnt_clk_in) pulses++;
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      results();
    end
  end
  // ======
  // Tasks.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic results;
    $display("checked %0d, failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : results
  task automatic note(input logic lvl, input int gap);
    notes.push_back({lvl, 15'(gap)});
  endtask : note
  task automatic at_pulse(input int k);
    @(negedge cnt_clk_in);
    repeat (k) @(posedge clk_in);
    #2;
  endtask : at_pulse
  task automatic drain(input string name);
    wait (notes.size() == 0);
    mute = 1'b1;
    @(posedge clk_in);
    #2;
    $display("test %s done", name);
  endtask : drain
  task automatic trigger;
    count_enable_in = 1'b0;
    at_pulse(3);
    count_enable_in = 1'b1;
    ref_p = pulses;
  endtask : trigger
  task automatic setup(input logic [2:0] mode, input logic two, input logic [15:0] cnt,
                       input logic gate);
    mute = 1'b1;
    count_enable_in = 1'b0;
    at_pulse(4);
    count_enable_in = gate;
    at_pulse(4);
    ictr_host_inst.put_ctrl(mode, two);
    mute = 1'b0;
    ictr_host_inst.put_count(cnt, two);
    ref_p = pulses;
  endtask : setup
  // ======
  // Output watcher: level and pulse gap of each edge.
  always @(waveform_out) begin
    if (!srst_in && !mute) begin
      check({waveform_out, 15'(pulses - ref_p)}, notes.size() != 0 ? notes.pop_front() : 16'hffff);
      ref_p = pulses;
    end
  end
  // ======
  // Main sequence.
  initial begin
    srst_in = 1'b1;
    count_enable_in = 1'b0;
    mute = 1'b1;
    void'($urandom(4));
    repeat (5) @(posedge clk_in);
    #2;
    srst_in = 1'b0;
    n = 2 + $urandom % 8;
    setup(3'h4, 1'b1, 16'(n), 1'b1);
    note(1'b0, n + 1);
    note(1'b1, 1);
    drain("mode 4 strobe");
    count_enable_in = 1'b0;
    repeat (3) at_pulse(4);
    count_enable_in = 1'b1;
    mute = 1'b0;
    at_pulse(4);
    ictr_host_inst.put_count(16'h0003, 1'b1);
    ref_p = pulses;
    note(1'b0, 4);
    note(1'b1, 1);
    drain("mode 4 reload");
    n = 2 + $urandom % 5;
    setup(3'h2, 1'b0, 16'(n), 1'b1);
    note(1'b0, n);
    note(1'b1, 1);
    note(1'b0, n - 1);
    wait (notes.size() == 0);
    note(1'b1, 0);
    #2;
    count_enable_in = 1'b0;
    trigger();
    note(1'b0, n);
    note(1'b1, 1);
    drain("mode 2 rate");
    for (int m = 4; m < 6; m++) begin
      setup(3'h3, 1'b0, 16'(m), 1'b1);
      note(1'b0, (m + 1) / 2 + 1);
      note(1'b1, m / 2);
      note(1'b0, (m + 1) / 2);
      drain("mode 3 square");
    end
    setup(3'h1, 1'b0, 16'h0003, 1'b0);
    trigger();
    note(1'b0, 1);
    at_pulse(4);
    ictr_host_inst.put_count(16'h0006, 1'b0);
    trigger();
    note(1'b1, 7);
    drain("mode 1 one shot");
    setup(3'h5, 1'b0, 16'h0003, 1'b0);
    trigger();
    at_pulse(4);
    ictr_host_inst.put_count(16'h0002, 1'b0);
    trigger();
    note(1'b0, 3);
    note(1'b1, 1);
    drain("mode 5 strobe");
    ictr_host_inst.ctrl_bcd_out = 1'b1;
    setup(3'h2, 1'b0, 16'h0010, 1'b1);
    note(1'b0, 10);
    note(1'b1, 1);
    drain("mode 2 decimal");
    results();
  end
endmodule : interval_counter_bench
